// ==== hdl/gpio_port_control.sv ====
// Purpose: 32-pin gpio port with AXI4-Lite register access
// Assumes: aresetn is the fundamental reset; hot reset never reaches here
// Notes: unmapped addresses answer SLVERR, read data zero
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_control
    import gpio_port_pkg::*;
#(
    parameter int PINS = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] alt_in,
    input wire logic [PINS-1:0] alt_out,
    input wire logic [PINS-1:0] alt_oe,
    output logic [PINS-1:0] pin_function_select,
    output logic [PINS-1:0] pin_direction
);
    // ==========================================================
    // state
    logic [PINS-1:0] func_sel_q, func_sel_d;
    logic [PINS-1:0] direction_q, direction_d;
    logic [PINS-1:0] out_value_q, out_value_d;
    logic [PINS-1:0] pin_level;
    wr_state_t wr_state_q, wr_state_d;
    rd_state_t rd_state_q, rd_state_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic aw_held_q, aw_held_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_held_q, w_held_d;
    logic [1:0] bresp_q, bresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] wmask;
    logic [31:0] plain_out;

    // ==========================================================
    // pin input synchroniser
    gpio_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    // ==========================================================
    // write channel
    assign s_axi_awready = (wr_state_q == wr_idle_s) && !aw_held_q;
    assign s_axi_wready = (wr_state_q == wr_idle_s) && !w_held_q;

    always_comb begin
        wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
            {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        plain_out = 32'(direction_q & ~func_sel_q);
        wr_state_d = wr_state_q;
        awaddr_d = awaddr_q;
        aw_held_d = aw_held_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_held_d = w_held_q;
        bresp_d = bresp_q;
        func_sel_d = func_sel_q;
        direction_d = direction_q;
        out_value_d = out_value_q;
        case (wr_state_q)
            wr_idle_s: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awaddr_d = s_axi_awaddr;
                    aw_held_d = 1'b1;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wdata_d = s_axi_wdata;
                    wstrb_d = s_axi_wstrb;
                    w_held_d = 1'b1;
                end
                if (aw_held_q && w_held_q) begin
                    aw_held_d = 1'b0;
                    w_held_d = 1'b0;
                    wr_state_d = wr_resp_s;
                    bresp_d = `AXI_RESP_OKAY;
                    if ({awaddr_q[11:2], 2'b00} ==
                        `GPIO_FUNC_SEL_OFFSET) begin
                        func_sel_d = PINS'((func_sel_q & ~wmask)
                            | (wdata_q & wmask));
                    end else if ({awaddr_q[11:2], 2'b00} ==
                        `GPIO_DIRECTION_OFFSET) begin
                        direction_d = PINS'((direction_q & ~wmask)
                            | (wdata_q & wmask));
                    end else if ({awaddr_q[11:2], 2'b00} ==
                        `GPIO_LEVEL_OFFSET) begin
                        // non-output pins keep their latch untouched
                        out_value_d = PINS'((out_value_q
                            & ~(wmask & plain_out))
                            | (wdata_q & wmask & plain_out));
                    end else begin
                        bresp_d = `AXI_RESP_SLVERR;
                    end
                end
            end
            wr_resp_s: begin
                if (s_axi_bready) begin
                    wr_state_d = wr_idle_s;
                end
            end
            default: begin
                wr_state_d = wr_idle_s;
            end
        endcase
    end

    // only the fundamental reset clears configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= wr_idle_s;
            awaddr_q <= 12'h000;
            aw_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_held_q <= 1'b0;
            bresp_q <= `AXI_RESP_OKAY;
            func_sel_q <= PINS'(`GPIO_FUNC_SEL_RESET);
            direction_q <= PINS'(`GPIO_DIRECTION_RESET);
            out_value_q <= PINS'(`GPIO_LEVEL_RESET);
        end else begin
            wr_state_q <= wr_state_d;
            awaddr_q <= awaddr_d;
            aw_held_q <= aw_held_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_held_q <= w_held_d;
            bresp_q <= bresp_d;
            func_sel_q <= func_sel_d;
            direction_q <= direction_d;
            out_value_q <= out_value_d;
        end
    end

    assign s_axi_bvalid = (wr_state_q == wr_resp_s);
    assign s_axi_bresp = bresp_q;

    // ==========================================================
    // read channel
    assign s_axi_arready = (rd_state_q == rd_idle_s);

    always_comb begin
        rd_state_d = rd_state_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rd_state_q)
            rd_idle_s: begin
                if (s_axi_arvalid) begin
                    rd_state_d = rd_resp_s;
                    rresp_d = `AXI_RESP_OKAY;
                    if ({s_axi_araddr[11:2], 2'b00} ==
                        `GPIO_FUNC_SEL_OFFSET) begin
                        rdata_d = 32'(func_sel_q);
                    end else if ({s_axi_araddr[11:2], 2'b00} ==
                        `GPIO_DIRECTION_OFFSET) begin
                        rdata_d = 32'(direction_q);
                    end else if ({s_axi_araddr[11:2], 2'b00} ==
                        `GPIO_LEVEL_OFFSET) begin
                        rdata_d = 32'(pin_level);
                    end else begin
                        rdata_d = 32'h0000_0000;
                        rresp_d = `AXI_RESP_SLVERR;
                    end
                end
            end
            rd_resp_s: begin
                if (s_axi_rready) begin
                    rd_state_d = rd_idle_s;
                end
            end
            default: begin
                rd_state_d = rd_idle_s;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= rd_idle_s;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `AXI_RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_rvalid = (rd_state_q == rd_resp_s);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // pin muxing
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (func_sel_q[i]) begin
                pin_out[i] = alt_out[i];
                pin_oe[i] = alt_oe[i];
            end else begin
                pin_out[i] = out_value_q[i];
                pin_oe[i] = direction_q[i];
            end
        end
    end

    assign alt_in = pin_level;
    assign pin_function_select = func_sel_q;
    assign pin_direction = direction_q;
endmodule // gpio_port_control

// ==== pkg/gpio_port_regs.svh ====
// Purpose: register map and reset values of the gpio port
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes: included by the port control module, the bench monitor and the testbench
//
// Functional notes
// - each function-select bit hands its pin to alternate function; resets zero
// - plain I/O pin with direction bit one is driven as output
// - direction bit zero leaves pin undriven as input; direction resets zero
// - alternate-function pins ignore direction; alternate logic drives them
// - pin-level read returns sampled level of all 32 pins in any mode
// - pin-level write changes only plain I/O output pins
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// ==========================================================
// register offsets
`define GPIO_FUNC_SEL_OFFSET 12'h418
`define GPIO_DIRECTION_OFFSET 12'h41c
`define GPIO_LEVEL_OFFSET 12'h420

// ==========================================================
// reset values
`define GPIO_FUNC_SEL_RESET 32'h0000_0000
`define GPIO_DIRECTION_RESET 32'h0000_0000
`define GPIO_LEVEL_RESET 32'h0000_0000

// ==========================================================
// bus responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ==== pkg/gpio_port_pkg.sv ====
// Purpose: shared types of the gpio port
// Assumes: nothing beyond the register header
// Notes: bus state encodings are one-hot
package gpio_port_pkg;
    typedef enum logic [1:0] {
        wr_idle_s = 2'b01,
        wr_resp_s = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        rd_idle_s = 2'b01,
        rd_resp_s = 2'b10
    } rd_state_t;
endpackage

// ==== hdl/gpio_sync.sv ====
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: one clock, synchronous active-low reset
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module gpio_sync #(
    parameter int WIDTH = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // gpio_sync

// ==== bench/gpio_port_monitor.sv ====
// Purpose: concurrent checks on the gpio port pins and bus
// Assumes: aresetn synchronous, active low; only top ports seen
// Notes: a subset of the top ports is watched
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_monitor #(
    parameter int PINS = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] alt_in,
    input wire logic [PINS-1:0] alt_out,
    input wire logic [PINS-1:0] alt_oe,
    input wire logic [PINS-1:0] pin_function_select,
    input wire logic [PINS-1:0] pin_direction
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [PINS-1:0] fs = pin_function_select;
    // ==========================================================
    // sequences
    sequence lvl_ar;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `GPIO_LEVEL_OFFSET;
    endsequence
    // pins held still long enough to pass both sync stages
    sequence pins_quiet;
        (aresetn && $stable(pin_in))[*4];
    endsequence
    // ==========================================================
    // checks
    AST_FUNC_ROUTE: assert property (
        ((pin_oe ^ alt_oe) & fs) == '0 && ((pin_out ^ alt_out) & fs) == '0)
        else $error("alternate pin not routed from alternate logic");
    AST_DIR_DRIVE: assert property (
        ((pin_oe ^ pin_direction) & ~fs) == '0)
        else $error("plain pin drive differs from direction");
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        !aresetn |=> fs == '0 && pin_direction == '0 && pin_oe == '0)
        else $error("config not cleared by reset");
    AST_LEVEL_READ: assert property (
        pins_quiet ##0 lvl_ar |=> s_axi_rdata == $past(pin_in))
        else $error("level read differs from pins");
    AST_LATCH_GUARD: assert property (
        ((pin_out ^ $past(pin_out)) & ~fs & ~$past(fs) & ~pin_direction)
        == '0)
        else $error("input pin output value changed");
    AST_SYNC_STAGES: assert property (
        $past(aresetn) && $past(aresetn, 2) |-> alt_in == $past(pin_in, 2))
        else $error("pin synchroniser depth wrong");
    AST_RD_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_CFG_ON_WRITE: assert property (
        $changed({fs, pin_direction}) |-> $rose(s_axi_bvalid))
        else $error("config changed without a write");
endmodule // gpio_port_monitor

bind gpio_port_control gpio_port_monitor #(.PINS(PINS)) i_mon (.*);

// ==== bench/gpio_far_end.sv ====
// Purpose: board pins and alternate-function logic beside the port
// Assumes: undriven pins settle to the board level set by the bench
// Notes: alternate logic registers its drive, as real logic does
`timescale 1ns/1ps
module gpio_far_end (
    input wire logic aclk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] board_level,
    input wire logic [31:0] alt_en,
    input wire logic [31:0] alt_val,
    output logic [31:0] pin_in,
    output logic [31:0] alt_out,
    output logic [31:0] alt_oe
);
    // ==========================================================
    // wire level: driven bits follow the port, others the board pull
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
    always_ff @(posedge aclk) begin
        alt_out <= alt_val;
        alt_oe <= alt_en;
    end
endmodule // gpio_far_end

// ==== bench/gpio_port_control_tb.sv ====
// Purpose: register-level bench for the gpio port
// Assumes: bready and rready held high; full strobes but for one write
// Notes: board level and alternate drive are set by the bench
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_control_tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = '0, board_level = '0;
    logic [31:0] alt_en = '0, alt_val = '0, d;
    logic [1:0] r;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, pin_in, pin_out, pin_oe, alt_in;
    wire logic [31:0] alt_out, alt_oe, pin_function_select, pin_direction;
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #20 aclk = ~aclk;
    gpio_port_control #(.PINS(32)) i_dut (.*);
    gpio_far_end i_far (.*);
    // ==========================================================
    // bus tasks
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a hang costs a mismatch, then the normal report
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ==========================================================
    // tests
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(`GPIO_FUNC_SEL_OFFSET);
        ck(d, `GPIO_FUNC_SEL_RESET);
        rd(`GPIO_DIRECTION_OFFSET);
        ck(d, `GPIO_DIRECTION_RESET);
        ck(pin_oe, 32'h0000_0000);
        board_level <= 32'ha5a5_3c3c;
        repeat (4) @(posedge aclk);
        rd(`GPIO_LEVEL_OFFSET);
        ck(d, 32'ha5a5_3c3c);
        wr(`GPIO_DIRECTION_OFFSET, 32'h0000_ffff);
        ck({30'h0, r}, {30'h0, `AXI_RESP_OKAY});
        wr(`GPIO_LEVEL_OFFSET, 32'h1234_5678);
        @(posedge aclk);
        ck(pin_oe, 32'h0000_ffff);
        ck(pin_out, 32'h0000_5678);
        repeat (4) @(posedge aclk);
        rd(`GPIO_LEVEL_OFFSET);
        ck(d, 32'ha5a5_5678);
        // mixed modes: alternate pins, plain outputs and inputs at once
        alt_en <= 32'hf0f0_f0f0;
        alt_val <= 32'hffff_0000;
        wr(`GPIO_FUNC_SEL_OFFSET, 32'hff00_00ff);
        wr(`GPIO_LEVEL_OFFSET, 32'hffff_ffff);
        @(posedge aclk);
        ck(pin_oe, 32'hf000_fff0);
        ck(pin_out, 32'hff00_ff00);
        ck(pin_function_select, 32'hff00_00ff);
        repeat (4) @(posedge aclk);
        rd(`GPIO_LEVEL_OFFSET);
        ck(d, 32'hf5a5_ff0c);
        wr(`GPIO_FUNC_SEL_OFFSET, 32'h0000_0000);
        @(posedge aclk);
        ck(pin_out, 32'h0000_ff78);
        rd(`GPIO_DIRECTION_OFFSET);
        ck(d, 32'h0000_ffff);
        // only byte lane 2 enabled: the other lanes keep their bits
        s_axi_wstrb <= 4'h4;
        wr(`GPIO_DIRECTION_OFFSET, 32'hffff_0000);
        s_axi_wstrb <= 4'hf;
        rd(`GPIO_DIRECTION_OFFSET);
        ck(d, 32'h00ff_ffff);
        ck(pin_direction, 32'h00ff_ffff);
        wr(12'h40c, 32'hffff_ffff);
        ck({30'h0, r}, {30'h0, `AXI_RESP_SLVERR});
        rd(12'h40c);
        ck({30'h0, r}, {30'h0, `AXI_RESP_SLVERR});
        ck(d, 32'h0000_0000);
        wrap_up();
    end
endmodule // gpio_port_control_tb
